/* irqc_pkg.sv */
package irqc_pkg;

  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          PIN_CNT        = 8;
  localparam int          VEC_W          = 16;

  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_PERIPHERAL_IRQ_ENABLE_1       = 8'h04;
  localparam logic [7:0]  OFS_OPTION     = 8'h08;
  localparam logic [7:0]  OFS_PIN_FLAGS  = 8'h0C;

  localparam int          B_GIE          = 7;
  localparam int          B_PERIPH_IRQ_EN         = 6;
  localparam int          B_T0_EN        = 5;
  localparam int          B_EXT_EN       = 4;
  localparam int          B_PC_EN        = 3;
  localparam int          B_T0_FLAG      = 2;
  localparam int          B_EXT_FLAG     = 1;
  localparam int          B_PC_FLAG      = 0;

  localparam int          B_T1G_EN       = 7;
  localparam int          B_CONV_EN      = 6;
  localparam int          B_RX_EN        = 5;
  localparam int          B_TX_EN        = 4;
  localparam int          B_SS_EN        = 3;
  localparam int          B_PERIPHERAL_IRQ_ENABLE_1_UNIMP   = 2;
  localparam int          B_T2_EN        = 1;
  localparam int          B_T1_EN        = 0;
  localparam logic [7:0]  PERIPHERAL_IRQ_ENABLE_1_MASK      = 8'hFB;
  localparam logic [7:0]  CONV_MASK      = 8'h40;

  localparam int          B_EDGE_SEL     = 0;

  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [7:0]  PERIPHERAL_IRQ_ENABLE_1_RST       = 8'h00;
  localparam logic [7:0]  PIN_FLAGS_RST  = 8'h00;
  localparam logic [VEC_W-1:0] IRQ_VECTOR = 16'h0004;

endpackage

/* irqc_top.sv */
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module irqc_top
#(
  parameter bit HAS_CONVERTER = 1'b1
)
(
  input  wire logic                           CLK_SYS_I,
  input  wire logic                           ARST_N_I,
  input  wire logic                           PSEL_I,
  input  wire logic                           PENABLE_I,
  input  wire logic                           PWRITE_I,
  input  wire logic [irqc_pkg::ADDR_W-1:0]    PADDR_I,
  input  wire logic [irqc_pkg::DATA_W-1:0]    PWDATA_I,
  output      logic [irqc_pkg::DATA_W-1:0]    PRDATA_O,
  output      logic                           PREADY_O,
  output      logic                           PSLVERR_O,
  input  wire logic                           TIMER0_OVF_I,
  input  wire logic                           EXT_PIN_I,
  input  wire logic [irqc_pkg::PIN_CNT-1:0]   PIN_CHANGE_I,
  input  wire logic [7:0]                     PERIPH_FLAGS_I,
  input  wire logic                           PERIPH2_REQ_I,
  input  wire logic                           IRQ_RETURN_I,
  output      logic                           IRQ_REQ_O,
  output      logic                           IRQ_TAKE_O,
  output      logic [irqc_pkg::VEC_W-1:0]     IRQ_VECTOR_O,
  output      logic                           PIN_CHANGE_PEND_O
);

  logic                          rst_s1_q;
  logic                          rst_n;

  logic [7:0]                    ctrl_q;
  logic [7:0]                    ctrl_d;
  logic [7:0]                    peripheral_irq_enable_1_q;
  logic [7:0]                    peripheral_irq_enable_1_d;
  logic                          edge_sel_q;
  logic                          edge_sel_d;
  logic [irqc_pkg::PIN_CNT-1:0]  pin_flags_q;
  logic [irqc_pkg::PIN_CNT-1:0]  pin_flags_d;
  logic                          ext_prev_q;
  logic                          take_q;
  logic [irqc_pkg::VEC_W-1:0]    vector_q;
  logic [irqc_pkg::DATA_W-1:0]   rdata_q;
  logic [irqc_pkg::DATA_W-1:0]   rdata_d;
  logic                          ext_prev_d;
  logic                          take_d;
  logic [irqc_pkg::VEC_W-1:0]    vector_d;

  logic                          wr_acc;
  logic                          rd_setup;
  logic                          hit;
  logic                          ext_edge;
  logic                          summary;
  logic                          core_pend;
  logic                          periph_pend;
  logic                          irq_req;
  logic [7:0]                    peripheral_irq_enable_1_wmask;
  logic [7:0]                    wbyte;
  logic                          gates_open;

  // reset release through two flops
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  function automatic logic addr_hit(input logic [irqc_pkg::ADDR_W-1:0] a);
    addr_hit = (a == irqc_pkg::OFS_CTRL) || (a == irqc_pkg::OFS_PERIPHERAL_IRQ_ENABLE_1) ||
               (a == irqc_pkg::OFS_OPTION) || (a == irqc_pkg::OFS_PIN_FLAGS);
  endfunction

  assign wbyte      = PWDATA_I[7:0];
  assign hit        = addr_hit(PADDR_I);
  assign wr_acc     = PSEL_I && PENABLE_I && PWRITE_I && hit;
  assign rd_setup   = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign PREADY_O   = 1'b1;
  assign PSLVERR_O  = PSEL_I && PENABLE_I && !hit;
  assign PRDATA_O   = rdata_q;

  // converter enable only exists on the converter variant
  // variant bit mask
  assign peripheral_irq_enable_1_wmask = HAS_CONVERTER ? irqc_pkg::PERIPHERAL_IRQ_ENABLE_1_MASK
                                    : (irqc_pkg::PERIPHERAL_IRQ_ENABLE_1_MASK & ~irqc_pkg::CONV_MASK);

  assign ext_edge   = edge_sel_q ? (EXT_PIN_I && !ext_prev_q) : (!EXT_PIN_I && ext_prev_q);

  assign summary    = |pin_flags_q;

  assign core_pend  = (ctrl_q[irqc_pkg::B_T0_EN]  && ctrl_q[irqc_pkg::B_T0_FLAG])  ||
                      (ctrl_q[irqc_pkg::B_EXT_EN] && ctrl_q[irqc_pkg::B_EXT_FLAG]) ||
                      (ctrl_q[irqc_pkg::B_PC_EN]  && summary);

  assign periph_pend = (|(peripheral_irq_enable_1_q & PERIPH_FLAGS_I)) || PERIPH2_REQ_I;

  assign irq_req    = ctrl_q[irqc_pkg::B_GIE] &&
                      (core_pend || (ctrl_q[irqc_pkg::B_PERIPH_IRQ_EN] && periph_pend));
  assign IRQ_REQ_O  = irq_req;
  assign IRQ_TAKE_O = take_q;
  assign IRQ_VECTOR_O      = vector_q;
  assign PIN_CHANGE_PEND_O = summary;

  // both gates open, for the per-source checks
  assign gates_open = ctrl_q[irqc_pkg::B_GIE] && ctrl_q[irqc_pkg::B_PERIPH_IRQ_EN];

  // control and flag register next values
  always_comb
  begin
    ctrl_d      = ctrl_q;
    peripheral_irq_enable_1_d      = peripheral_irq_enable_1_q;
    edge_sel_d  = edge_sel_q;
    pin_flags_d = pin_flags_q;
    if (wr_acc && PADDR_I == irqc_pkg::OFS_CTRL)
    begin
      ctrl_d[7:1] = wbyte[7:1];
    end
    if (wr_acc && PADDR_I == irqc_pkg::OFS_PERIPHERAL_IRQ_ENABLE_1)
    begin
      peripheral_irq_enable_1_d = wbyte & peripheral_irq_enable_1_wmask;
    end
    if (wr_acc && PADDR_I == irqc_pkg::OFS_OPTION)
    begin
      edge_sel_d = wbyte[irqc_pkg::B_EDGE_SEL];
    end
    if (wr_acc && PADDR_I == irqc_pkg::OFS_PIN_FLAGS)
    begin
      pin_flags_d = pin_flags_q & wbyte;
    end
    if (TIMER0_OVF_I)
    begin
      ctrl_d[irqc_pkg::B_T0_FLAG] = 1'b1;
    end
    if (ext_edge)
    begin
      ctrl_d[irqc_pkg::B_EXT_FLAG] = 1'b1;
    end
    pin_flags_d = pin_flags_d | PIN_CHANGE_I;
    if (IRQ_RETURN_I)
    begin
      ctrl_d[irqc_pkg::B_GIE] = 1'b1;
    end
    if (irq_req)
    begin
      ctrl_d[irqc_pkg::B_GIE] = 1'b0;
    end
    ctrl_d[irqc_pkg::B_PC_FLAG] = |pin_flags_d;
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q      <= irqc_pkg::CTRL_RST;
      peripheral_irq_enable_1_q      <= irqc_pkg::PERIPHERAL_IRQ_ENABLE_1_RST;
      edge_sel_q  <= 1'b0;
      pin_flags_q <= irqc_pkg::PIN_FLAGS_RST;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      peripheral_irq_enable_1_q      <= peripheral_irq_enable_1_d;
      edge_sel_q  <= edge_sel_d;
      pin_flags_q <= pin_flags_d;
    end
  end

  // read data captured in the setup phase
  always_comb
  begin
    rdata_d = rdata_q;
    if (rd_setup)
    begin
      rdata_d = '0;
      unique case (PADDR_I)
        irqc_pkg::OFS_CTRL:      rdata_d[7:0] = ctrl_q;
        irqc_pkg::OFS_PERIPHERAL_IRQ_ENABLE_1:      rdata_d[7:0] = peripheral_irq_enable_1_q;
        irqc_pkg::OFS_OPTION:    rdata_d[irqc_pkg::B_EDGE_SEL] = edge_sel_q;
        irqc_pkg::OFS_PIN_FLAGS: rdata_d[irqc_pkg::PIN_CNT-1:0] = pin_flags_q;
        default:                 rdata_d = '0;
      endcase
    end
  end

  // pin history and entry pulse next values
  always_comb
  begin
    ext_prev_d = EXT_PIN_I;
    take_d     = irq_req;
    vector_d   = irqc_pkg::IRQ_VECTOR;
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q    <= '0;
      ext_prev_q <= 1'b0;
      take_q     <= 1'b0;
      vector_q   <= '0;
    end
    else
    begin
      rdata_q    <= rdata_d;
      ext_prev_q <= ext_prev_d;
      take_q     <= take_d;
      vector_q   <= vector_d;
    end
  end

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!rst_n);

  gie_blocks_a: assert property (!ctrl_q[irqc_pkg::B_GIE] |-> !IRQ_REQ_O)
    else $error("request while global enable clear");

  periph_gate_a: assert property (IRQ_REQ_O && !core_pend |-> ctrl_q[irqc_pkg::B_PERIPH_IRQ_EN])
    else $error("peripheral request without peripheral enable");

  timer0_sets_a: assert property (TIMER0_OVF_I |=> ctrl_q[irqc_pkg::B_T0_FLAG])
    else $error("timer0 overflow did not set flag");

  timer0_sticky_a: assert property (ctrl_q[irqc_pkg::B_T0_FLAG] && !wr_acc
                                    |=> ctrl_q[irqc_pkg::B_T0_FLAG])
    else $error("timer0 flag dropped without write");

  ext_edge_a: assert property (edge_sel_q && $rose(EXT_PIN_I) |=>
                               ctrl_q[irqc_pkg::B_EXT_FLAG])
    else $error("rising edge not flagged");

  summary_flag_a: assert property (ctrl_q[irqc_pkg::B_PC_FLAG] == (|pin_flags_q))
    else $error("summary flag disagrees with pin flags");

  unimp_bit_a: assert property (peripheral_irq_enable_1_q[irqc_pkg::B_PERIPHERAL_IRQ_ENABLE_1_UNIMP] == 1'b0)
    else $error("unimplemented enable bit set");

  take_clears_a: assert property (IRQ_REQ_O |=> !ctrl_q[irqc_pkg::B_GIE] &&
                                  IRQ_TAKE_O && IRQ_VECTOR_O == irqc_pkg::IRQ_VECTOR)
    else $error("taken request did not clear enable");

  core_req_a: assert property (ctrl_q[irqc_pkg::B_GIE] && ctrl_q[irqc_pkg::B_T0_EN] &&
                               ctrl_q[irqc_pkg::B_T0_FLAG] |-> IRQ_REQ_O)
    else $error("enabled timer0 flag gave no request");

  ext_req_a: assert property (ctrl_q[irqc_pkg::B_GIE] && ctrl_q[irqc_pkg::B_EXT_EN] &&
                              ctrl_q[irqc_pkg::B_EXT_FLAG] |-> IRQ_REQ_O)
    else $error("enabled external flag gave no request");

  pc_req_a: assert property (ctrl_q[irqc_pkg::B_GIE] && ctrl_q[irqc_pkg::B_PC_EN] &&
                             ctrl_q[irqc_pkg::B_PC_FLAG] |-> IRQ_REQ_O)
    else $error("enabled pin change flag gave no request");

  src_masked_a: assert property (!ctrl_q[irqc_pkg::B_T0_EN] &&
                                 !ctrl_q[irqc_pkg::B_EXT_EN] && !ctrl_q[irqc_pkg::B_PC_EN] &&
                                 !ctrl_q[irqc_pkg::B_PERIPH_IRQ_EN] |-> !IRQ_REQ_O)
    else $error("request with every source enable clear");

  ext_fall_a: assert property ($past(rst_n) && !edge_sel_q && $fell(EXT_PIN_I) |=>
                               ctrl_q[irqc_pkg::B_EXT_FLAG])
    else $error("falling edge not flagged");

  ext_sticky_a: assert property (ctrl_q[irqc_pkg::B_EXT_FLAG] && !wr_acc |=>
                                 ctrl_q[irqc_pkg::B_EXT_FLAG])
    else $error("external flag dropped without write");

  pin_event_a: assert property ((|PIN_CHANGE_I) |=> ctrl_q[irqc_pkg::B_PC_FLAG] &&
                                PIN_CHANGE_PEND_O)
    else $error("pin change not shown in summary");

  summary_ro_a: assert property (ctrl_q[irqc_pkg::B_PC_FLAG] &&
                                 !(wr_acc && PADDR_I == irqc_pkg::OFS_PIN_FLAGS)
                                 |=> ctrl_q[irqc_pkg::B_PC_FLAG])
    else $error("summary flag cleared while pin flags stood");

  summary_clr_a: assert property (wr_acc && PADDR_I == irqc_pkg::OFS_PIN_FLAGS &&
                                  !(|PIN_CHANGE_I) &&
                                  !(|(pin_flags_q & PWDATA_I[irqc_pkg::PIN_CNT-1:0]))
                                  |=> !ctrl_q[irqc_pkg::B_PC_FLAG])
    else $error("summary flag stuck after pin flags cleared");

  ret_sets_a: assert property (IRQ_RETURN_I && !IRQ_REQ_O |=> ctrl_q[irqc_pkg::B_GIE])
    else $error("return did not set global enable");

  gie_write_a: assert property (wr_acc && PADDR_I == irqc_pkg::OFS_CTRL &&
                                !IRQ_REQ_O && !IRQ_RETURN_I |=>
                                ctrl_q[irqc_pkg::B_GIE] == $past(PWDATA_I[irqc_pkg::B_GIE]))
    else $error("global enable write lost");

  t1_gate_en_a: assert property (gates_open && peripheral_irq_enable_1_q[irqc_pkg::B_T1G_EN] &&
                                 PERIPH_FLAGS_I[irqc_pkg::B_T1G_EN] |-> IRQ_REQ_O)
    else $error("timer1 gate flag gave no request");

  conv_en_a: assert property (gates_open && peripheral_irq_enable_1_q[irqc_pkg::B_CONV_EN] &&
                              PERIPH_FLAGS_I[irqc_pkg::B_CONV_EN] |-> IRQ_REQ_O)
    else $error("converter flag gave no request");

  rx_en_a: assert property (gates_open && peripheral_irq_enable_1_q[irqc_pkg::B_RX_EN] &&
                            PERIPH_FLAGS_I[irqc_pkg::B_RX_EN] |-> IRQ_REQ_O)
    else $error("receive flag gave no request");

  tx_en_a: assert property (gates_open && peripheral_irq_enable_1_q[irqc_pkg::B_TX_EN] &&
                            PERIPH_FLAGS_I[irqc_pkg::B_TX_EN] |-> IRQ_REQ_O)
    else $error("transmit flag gave no request");

  sync_en_a: assert property (gates_open && peripheral_irq_enable_1_q[irqc_pkg::B_SS_EN] &&
                              PERIPH_FLAGS_I[irqc_pkg::B_SS_EN] |-> IRQ_REQ_O)
    else $error("sync serial flag gave no request");

  t2_en_a: assert property (gates_open && peripheral_irq_enable_1_q[irqc_pkg::B_T2_EN] &&
                            PERIPH_FLAGS_I[irqc_pkg::B_T2_EN] |-> IRQ_REQ_O)
    else $error("timer2 match flag gave no request");

  t1_ovf_en_a: assert property (gates_open && peripheral_irq_enable_1_q[irqc_pkg::B_T1_EN] &&
                                PERIPH_FLAGS_I[irqc_pkg::B_T1_EN] |-> IRQ_REQ_O)
    else $error("timer1 overflow flag gave no request");

  periph2_en_a: assert property (gates_open && PERIPH2_REQ_I |-> IRQ_REQ_O)
    else $error("second group request not passed");

  periph_block_a: assert property (!ctrl_q[irqc_pkg::B_PERIPH_IRQ_EN] && !core_pend
                                   |-> !IRQ_REQ_O)
    else $error("peripheral request passed a closed gate");

  take_once_a: assert property (IRQ_TAKE_O |=> !IRQ_TAKE_O)
    else $error("entry pulse longer than one cycle");

  ctrl_read_a: assert property (rd_setup && PADDR_I == irqc_pkg::OFS_CTRL |=>
                                PRDATA_O[7:0] == $past(ctrl_q) && PRDATA_O[31:8] == '0)
    else $error("control read data wrong");

  pie_read_a: assert property (rd_setup && PADDR_I == irqc_pkg::OFS_PERIPHERAL_IRQ_ENABLE_1 |=>
                               PRDATA_O[7:0] == $past(peripheral_irq_enable_1_q) && PRDATA_O[31:8] == '0)
    else $error("enable register read data wrong");

endmodule

/* irqc_core_model.sv */
`timescale 1ns/1ps
module irqc_core_model
(
  input  wire logic        clk_i,
  input  wire logic        ret_en_i,
  input  wire logic        take_i,
  input  wire logic [15:0] vector_i,
  output      logic        ret_o,
  output      int          takes_o,
  output      int          bad_vec_o
);
  int cnt;
  initial
  begin
    ret_o = 1'b0;
    takes_o = 0;
    bad_vec_o = 0;
    cnt = 0;
  end
  // return pulse comes some cycles after entry, only when enabled
  always @(posedge clk_i)
  begin
    ret_o <= 1'b0;
    if (take_i === 1'b1)
    begin
      takes_o <= takes_o + 1;
      if (vector_i !== 16'h0004)
        bad_vec_o <= bad_vec_o + 1;
      cnt <= ret_en_i ? 8 : 0;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      ret_o <= (cnt == 1);
    end
  end
endmodule

/* irq_enable_and_flag_control_tb.sv */
`timescale 1ns/1ps
module irq_enable_and_flag_control_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        t0 = 1'b0;
  logic        ext = 1'b0;
  logic        p2 = 1'b0;
  logic        ret_en = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [7:0]  pin = 8'h00;
  logic [7:0]  pf = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, req, take, pend, ret, w;
  logic [15:0] vec;
  logic [7:0]  ctl, pie;
  int          bad_count = 0;
  int          num_checks = 0;
  int          seed = 32'hdfaf;
  int          nt = 0;
  int          takes, bad_vec;
  always #2.5 clk = ~clk;
  irqc_top dut
  (
    .CLK_SYS_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .TIMER0_OVF_I(t0), .EXT_PIN_I(ext), .PIN_CHANGE_I(pin),
    .PERIPH_FLAGS_I(pf), .PERIPH2_REQ_I(p2), .IRQ_RETURN_I(ret), .IRQ_REQ_O(req),
    .IRQ_TAKE_O(take), .IRQ_VECTOR_O(vec), .PIN_CHANGE_PEND_O(pend)
  );
  irqc_core_model core
  (
    .clk_i(clk), .ret_en_i(ret_en), .take_i(take), .vector_i(vec), .ret_o(ret),
    .takes_o(takes), .bad_vec_o(bad_vec)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(rd, want);
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic exp_req(input logic [7:0] c, p, f, input logic q);
    return c[7] & ((|(c[5:3] & c[2:0])) | (c[6] & ((|(p & f & 8'hFB)) | q)));
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #20us;
    bad_count++;
    test_done();
  end
  initial
  begin
    do_reset();
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    $display("reset test done");
    repeat (12)
    begin
      wr(8'h00, 32'h0);
      pf <= $random(seed);
      p2 <= $random(seed);
      pie = $random(seed);
      ctl = $random(seed) & 8'hFE;
      wr(8'h04, {24'h0, pie});
      rdc(8'h04, {24'h0, pie & 8'hFB});
      wr(8'h00, {24'h0, ctl | 8'h01});
      w = exp_req(ctl, pie, pf, p2);
      nt += w;
      #1 chk(req, w);
      rdc(8'h00, {24'h0, ctl[7] & !w, ctl[6:0]});
    end
    $display("random test done");
    wr(8'h00, 32'h0);
    @(posedge clk);
    t0 <= 1'b1;
    @(posedge clk);
    t0 <= 1'b0;
    rdc(8'h00, 32'h04);
    for (int s = 0; s < 2; s++)
    begin
      ext <= s[0];
      wr(8'h08, s);
      wr(8'h00, 32'h0);
      ext <= !s[0];
      repeat (2) @(posedge clk);
      rdc(8'h00, 32'h0);
      ext <= s[0];
      repeat (2) @(posedge clk);
      rdc(8'h00, 32'h02);
    end
    $display("edge test done");
    wr(8'h00, 32'h0);
    ret_en <= 1'b1;
    @(posedge clk);
    pin <= 8'h81;
    @(posedge clk);
    pin <= 8'h00;
    #1 chk(pend, 1'b1);
    wr(8'h0C, 32'h80);
    wr(8'h00, 32'h0);
    rdc(8'h00, 32'h01);
    wr(8'h00, 32'h88);
    nt++;
    #1 chk(req, 1'b1);
    wr(8'h0C, 32'h0);
    #1 chk(pend, 1'b0);
    repeat (10) @(posedge clk);
    rdc(8'h00, 32'h88);
    chk(takes, nt);
    chk(bad_vec, 0);
    $display("pin change test done");
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("bus error test done");
    wr(8'h04, 32'hFF);
    do_reset();
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    $display("second reset test done");
    test_done();
  end
endmodule
